// File: src/ttsos_top.sv
// T1 transmit framer sync and overhead source selection, one channel.
// Assumes the system side runs off tx_serial_clock; serial and boundary pins are synchronised here, recovered_clock_tick_in is not.
`timescale 1ns/1ps
module ttsos_top (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	input wire logic tx_serial_clock_in,
	input wire logic tx_serial_data_in,
	input wire logic recovered_clock_tick_in,
	input wire logic tx_frame_boundary_in,
	output logic tx_frame_boundary_out,
	output logic tx_frame_boundary_oe_out,
	input wire logic tx_multiframe_boundary_in,
	output logic tx_multiframe_boundary_out,
	output logic tx_multiframe_boundary_oe_out,
	output logic tx_line_data_out,
	output logic tx_line_strobe_out
);
	// Configuration
	logic [1:0] tx_clock_source_sel_reg;
	logic frame_sync_sel_reg;
	logic crc_src_reg;
	logic fbit_src_reg;
	logic crc_align_en_reg;
	logic [7:0] rdata_reg;

	// Pin sampling
	logic [3:0] pin_level;
	logic serclk_level;
	logic serclk_prev_reg;
	logic serclk_rise;
	logic ser_data;
	logic frame_pin;
	logic mframe_pin;

	// Timing and position
	logic [4:0] div_cnt_reg;
	logic int_tick;
	logic bit_tick;
	logic chip_control;
	logic [1:0] clock_sel_next;
	logic frame_sync_next;
	logic chip_control_next;
	logic sys_frame_start;
	logic sys_mframe_start;
	logic [7:0] bit_cnt_reg;
	logic [4:0] frame_cnt_reg;
	logic [7:0] cur_bit;
	logic [4:0] cur_frame;
	logic [4:0] frame_after;

	// Overhead
	logic [5:0] crc_now;
	logic [5:0] crc_hold_reg;
	logic crc_clear;
	logic crc_data;
	logic [2:0] group;
	logic is_fbit;
	logic is_crc_slot;
	logic is_fps_slot;
	logic crc_external;
	logic out_bit;
	logic line_data_reg;
	logic line_strobe_reg;
	logic frame_bnd_reg;
	logic mframe_bnd_reg;

	// Register writes
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_clock_source_sel_reg <= ttsos_pkg::CLK_SEL_RESET;
			frame_sync_sel_reg <= ttsos_pkg::FRAME_SYNC_SEL_RESET;
			crc_src_reg <= ttsos_pkg::CRC_SRC_RESET;
			fbit_src_reg <= ttsos_pkg::FBIT_SRC_RESET;
			crc_align_en_reg <= ttsos_pkg::CRC_ALIGN_EN_RESET;
		end else if (reg_write_in) begin
			unique case (reg_addr_in)
				ttsos_pkg::CLOCK_SELECT_ADDR: begin
					tx_clock_source_sel_reg <=
						reg_wdata_in[ttsos_pkg::CLK_SEL_LSB +: 2];
				end
				ttsos_pkg::SYNC_MUX_CONTROL_ADDR: begin
					frame_sync_sel_reg <= reg_wdata_in[ttsos_pkg::FRAME_SYNC_SEL_BIT];
					crc_src_reg <= reg_wdata_in[ttsos_pkg::CRC_SRC_BIT];
					fbit_src_reg <= reg_wdata_in[ttsos_pkg::FBIT_SRC_BIT];
				end
				ttsos_pkg::FRAMER_CONFIG_ADDR: begin
					crc_align_en_reg <= reg_wdata_in[ttsos_pkg::CRC_ALIGN_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads: data stand in the cycle after the strobe only
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_reg <= 8'h00;
		end else if (reg_read_in) begin
			rdata_reg <= 8'h00;
			unique case (reg_addr_in)
				ttsos_pkg::CLOCK_SELECT_ADDR: begin
					rdata_reg[ttsos_pkg::CLK_SEL_LSB +: 2] <= tx_clock_source_sel_reg;
				end
				ttsos_pkg::SYNC_MUX_CONTROL_ADDR: begin
					rdata_reg[ttsos_pkg::FRAME_SYNC_SEL_BIT] <= frame_sync_sel_reg;
					rdata_reg[ttsos_pkg::CRC_SRC_BIT] <= crc_src_reg;
					rdata_reg[ttsos_pkg::FBIT_SRC_BIT] <= fbit_src_reg;
				end
				ttsos_pkg::FRAMER_CONFIG_ADDR: begin
					rdata_reg[ttsos_pkg::CRC_ALIGN_EN_BIT] <= crc_align_en_reg;
				end
				ttsos_pkg::FRAMER_STATUS_ADDR: begin
					rdata_reg[ttsos_pkg::STATUS_CHIP_CTRL_BIT] <= chip_control;
					rdata_reg[4:0] <= frame_cnt_reg;
				end
				default: begin
				end
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata_out = rdata_reg;

	// Pins from the backplane domain
	ttsos_pin_sync #(
		.W(ttsos_pkg::SYNC_W)
	) u_pin_sync (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.async_in({tx_multiframe_boundary_in, tx_frame_boundary_in,
			tx_serial_data_in, tx_serial_clock_in}),
		.level_out(pin_level)
	);

	assign serclk_level = pin_level[0];
	assign ser_data = pin_level[1];
	assign frame_pin = pin_level[2];
	assign mframe_pin = pin_level[3];

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			serclk_prev_reg <= 1'b0;
		end else begin
			serclk_prev_reg <= serclk_level;
		end
	end

	assign serclk_rise = serclk_level & ~serclk_prev_reg;

	// Internal bit clock divider
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_cnt_reg <= 5'h00;
		end else if (div_cnt_reg == ttsos_pkg::INT_DIV_LAST) begin
			div_cnt_reg <= 5'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 5'h01;
		end
	end

	assign int_tick = (div_cnt_reg == ttsos_pkg::INT_DIV_LAST);

	// Bit timing source and who controls framing
	always_comb begin
		unique case (tx_clock_source_sel_reg)
			ttsos_pkg::CLK_SEL_SERIAL: begin
				bit_tick = serclk_rise;
				chip_control = frame_sync_sel_reg;
			end
			ttsos_pkg::CLK_SEL_INTERNAL: begin
				bit_tick = int_tick;
				chip_control = ~frame_sync_sel_reg;
			end
			default: begin
				bit_tick = recovered_clock_tick_in;
				chip_control = ~frame_sync_sel_reg;
			end
		endcase
	end

	// Boundary pin direction follows the controlling party
	assign tx_frame_boundary_oe_out = chip_control;
	assign tx_multiframe_boundary_oe_out = chip_control;

	// Direction the configuration gives after this edge, so that a write handing
	// framing to the system never leaves a boundary pulse standing on a pin
	// that has just turned input
	always_comb begin
		clock_sel_next = tx_clock_source_sel_reg;
		frame_sync_next = frame_sync_sel_reg;
		if (reg_write_in && reg_addr_in == ttsos_pkg::CLOCK_SELECT_ADDR) begin
			clock_sel_next = reg_wdata_in[ttsos_pkg::CLK_SEL_LSB +: 2];
		end
		if (reg_write_in && reg_addr_in == ttsos_pkg::SYNC_MUX_CONTROL_ADDR) begin
			frame_sync_next = reg_wdata_in[ttsos_pkg::FRAME_SYNC_SEL_BIT];
		end
		if (clock_sel_next == ttsos_pkg::CLK_SEL_SERIAL) begin
			chip_control_next = frame_sync_next;
		end else begin
			chip_control_next = ~frame_sync_next;
		end
	end

	assign sys_frame_start = ~chip_control & frame_pin;
	assign sys_mframe_start = ~chip_control & mframe_pin;

	// Position of the bit going out on this tick
	always_comb begin
		frame_after = (frame_cnt_reg == ttsos_pkg::LAST_FRAME) ? 5'h00 :
			frame_cnt_reg + 5'h01;
		cur_bit = sys_frame_start ? 8'h00 : bit_cnt_reg;
		if (sys_mframe_start) begin
			cur_frame = 5'h00;
		end else if (sys_frame_start && bit_cnt_reg != 8'h00) begin
			cur_frame = frame_after;
		end else begin
			cur_frame = frame_cnt_reg;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bit_cnt_reg <= 8'h00;
			frame_cnt_reg <= 5'h00;
		end else if (bit_tick) begin
			if (cur_bit == ttsos_pkg::LAST_BIT) begin
				bit_cnt_reg <= 8'h00;
				frame_cnt_reg <= (cur_frame == ttsos_pkg::LAST_FRAME) ? 5'h00 :
					cur_frame + 5'h01;
			end else begin
				bit_cnt_reg <= cur_bit + 8'h01;
				frame_cnt_reg <= cur_frame;
			end
		end
	end

	// Overhead slot decode, extended superframe layout
	always_comb begin
		group = 3'(cur_frame >> 2);
		is_fbit = (cur_bit == 8'h00);
		is_crc_slot = is_fbit & (cur_frame[1:0] == 2'h1);
		is_fps_slot = is_fbit & (cur_frame[1:0] == 2'h3);
	end

	// CRC is computed over the payload with every framing bit taken as one
	assign crc_clear = is_fbit & (cur_frame == 5'h00);
	assign crc_data = is_fbit ? 1'b1 : ser_data;

	ttsos_crc6 u_crc6 (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.enable_in(bit_tick),
		.clear_in(crc_clear),
		.data_in(crc_data),
		.crc_out(crc_now)
	);

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			crc_hold_reg <= 6'h00;
		end else if (bit_tick && crc_clear) begin
			crc_hold_reg <= crc_now;
		end
	end

	// Source bit only counts while CRC multiframe alignment is on
	assign crc_external = crc_src_reg & crc_align_en_reg;

	always_comb begin
		out_bit = ser_data;
		if (is_fbit) begin
			if (fbit_src_reg) begin
				out_bit = ser_data;
			end else if (is_crc_slot) begin
				if (crc_external) begin
					out_bit = ser_data;
				end else begin
					out_bit = crc_hold_reg[3'd5 - group];
				end
			end else if (is_fps_slot) begin
				out_bit = ttsos_pkg::FPS_PATTERN[3'd5 - group];
			end else begin
				// Data link slots idle at one
				out_bit = 1'b1;
			end
		end
	end

	// Line output and boundary pulses, one bit period each
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_data_reg <= 1'b0;
			line_strobe_reg <= 1'b0;
		end else begin
			line_strobe_reg <= bit_tick;
			if (bit_tick) begin
				line_data_reg <= out_bit;
			end
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			frame_bnd_reg <= 1'b0;
			mframe_bnd_reg <= 1'b0;
		end else if (!chip_control_next) begin
			frame_bnd_reg <= 1'b0;
			mframe_bnd_reg <= 1'b0;
		end else if (bit_tick) begin
			frame_bnd_reg <= chip_control & is_fbit;
			mframe_bnd_reg <= chip_control & crc_clear;
		end
	end

	assign tx_line_data_out = line_data_reg;
	assign tx_line_strobe_out = line_strobe_reg;
	assign tx_frame_boundary_out = frame_bnd_reg;
	assign tx_multiframe_boundary_out = mframe_bnd_reg;
endmodule

// File: inc/ttsos_pkg.sv
// Constants for the T1 transmit sync and overhead select block.
// Assumes a 40 MHz system clock and a 12-bit register address port.
package ttsos_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [11:0] CLOCK_SELECT_ADDR = 12'h100;
	localparam logic [11:0] SYNC_MUX_CONTROL_ADDR = 12'h109;
	localparam logic [11:0] FRAMER_CONFIG_ADDR = 12'h1f0;
	localparam logic [11:0] FRAMER_STATUS_ADDR = 12'h1f1;
	// Field positions
	localparam int CLK_SEL_LSB = 0;
	localparam int FRAME_SYNC_SEL_BIT = 4;
	localparam int CRC_SRC_BIT = 1;
	localparam int FBIT_SRC_BIT = 0;
	localparam int CRC_ALIGN_EN_BIT = 0;
	localparam int STATUS_CHIP_CTRL_BIT = 7;
	// Reset values
	localparam logic [1:0] CLK_SEL_RESET = 2'h0;
	localparam logic FRAME_SYNC_SEL_RESET = 1'b0;
	localparam logic CRC_SRC_RESET = 1'b0;
	localparam logic FBIT_SRC_RESET = 1'b0;
	localparam logic CRC_ALIGN_EN_RESET = 1'b1;
	// Transmit clock source codes
	localparam logic [1:0] CLK_SEL_SERIAL = 2'h1;
	localparam logic [1:0] CLK_SEL_INTERNAL = 2'h2;
	// Frame geometry
	localparam logic [7:0] LAST_BIT = 8'd192;
	localparam logic [4:0] LAST_FRAME = 5'd23;
	localparam logic [5:0] FPS_PATTERN = 6'h0b;
	localparam logic [5:0] CRC6_POLY = 6'h03;
	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int T1_BIT_HZ = 1544000;
	localparam int INT_DIV = (CLK_HZ + T1_BIT_HZ / 2) / T1_BIT_HZ;
	localparam logic [4:0] INT_DIV_LAST = 5'(INT_DIV - 1);
	// Synchronised inputs: serial clock, data, frame and multiframe boundary
	localparam int SYNC_W = 4;
endpackage

// File: src/ttsos_pin_sync.sv
// Three flip-flop synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous inputs from pins; output changes once stages two and three agree.
`timescale 1ns/1ps
module ttsos_pin_sync #(
	parameter int W = 4
) (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic level_reg;
			always_ff @(posedge clock_in or negedge resetn_in) begin
				if (!resetn_in) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					level_reg <= 1'b0;
				end else begin
					s1_reg <= async_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						level_reg <= s3_reg;
					end
				end
			end
			assign level_out[i] = level_reg;
		end
	endgenerate
endmodule

// File: src/ttsos_crc6.sv
// Serial CRC-6 engine over one multiframe, generator x^6 + x + 1.
// Assumes one bit per enable pulse; clear restarts from zero with the current bit.
`timescale 1ns/1ps
module ttsos_crc6 (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic enable_in,
	input wire logic clear_in,
	input wire logic data_in,
	output logic [5:0] crc_out
);
	logic [5:0] crc_reg;
	logic [5:0] base;
	logic feedback;

	always_comb begin
		base = clear_in ? 6'h00 : crc_reg;
		feedback = data_in ^ base[5];
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			crc_reg <= 6'h00;
		end else if (enable_in) begin
			crc_reg <= {base[4:0], 1'b0} ^ (feedback ? ttsos_pkg::CRC6_POLY : 6'h00);
		end
	end

	assign crc_out = crc_reg;
endmodule

// File: testbench/ttsos_top_props.sv
// Checker for ttsos_top: pin direction, quiet inputs, register read timing.
// Assumes one clock domain; bound to every ttsos_top instance.
`timescale 1ns/1ps
module ttsos_top_props (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic tx_frame_boundary_out,
	input wire logic tx_frame_boundary_oe_out,
	input wire logic tx_multiframe_boundary_out,
	input wire logic tx_multiframe_boundary_oe_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	sequence s_rd_mux;
		reg_read_in && reg_addr_in == 12'h109;
	endsequence
	sequence s_rd_far;
		reg_read_in && reg_addr_in[11:8] != 4'h1;
	endsequence
	a_pins_same_dir:
	assert property (tx_frame_boundary_oe_out == tx_multiframe_boundary_oe_out)
		else $error("boundary pins differ in direction");
	a_frame_in_quiet:
	assert property (!tx_frame_boundary_oe_out |-> !tx_frame_boundary_out)
		else $error("frame boundary driven while input");
	a_mframe_in_quiet:
	assert property (!tx_multiframe_boundary_oe_out |-> !tx_multiframe_boundary_out)
		else $error("multiframe boundary driven while input");
	a_mframe_on_frame:
	assert property (tx_multiframe_boundary_out |-> tx_frame_boundary_out)
		else $error("multiframe start off a frame start");
	a_dir_by_write:
	assert property ($changed(tx_frame_boundary_oe_out) |-> $past(reg_write_in))
		else $error("pin direction moved without a write");
	a_mux_reserved:
	assert property (s_rd_mux |=> (reg_rdata_out & 8'hec) == 8'h00)
		else $error("reserved mux bits read nonzero");
	a_far_read_zero:
	assert property (s_rd_far |=> reg_rdata_out == 8'h00)
		else $error("unmapped read nonzero");
	a_rdata_one_cycle:
	assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside its cycle");
endmodule

bind ttsos_top ttsos_top_props ttsos_top_props_inst (.clock_in, .resetn_in, .reg_addr_in,
	.reg_write_in, .reg_read_in, .reg_rdata_out, .tx_frame_boundary_out,
	.tx_frame_boundary_oe_out, .tx_multiframe_boundary_out, .tx_multiframe_boundary_oe_out);

// File: testbench/ttsos_sys_model.sv
// Backplane model: free-running serial clock, serial data, frame pulses.
// Assumes the bench resolves the boundary pins; a frame is FRAME_BITS bits.
`timescale 1ns/1ps
module ttsos_sys_model #(
	parameter int FRAME_BITS = 20
) (
	input wire logic enable_in,
	input wire logic data_level_in,
	output logic tx_serial_clock_out,
	output logic tx_serial_data_out,
	output logic frame_out,
	output logic mframe_out,
	output logic [4:0] frame_idx_out
);
	int bit_cnt = 0;
	initial begin
		{tx_serial_clock_out, tx_serial_data_out, frame_out, mframe_out} = 4'h0;
		frame_idx_out = 5'h00;
		#37;
		forever #100 tx_serial_clock_out = ~tx_serial_clock_out;
	end
	// Changes on the falling edge so the device samples stable levels
	always @(negedge tx_serial_clock_out) begin
		bit_cnt = (bit_cnt + 1) % FRAME_BITS;
		if (bit_cnt == 0)
			frame_idx_out = (frame_idx_out == 5'h17) ? 5'h00 : frame_idx_out + 5'h01;
		frame_out = enable_in ? (bit_cnt == 0) : 1'($urandom);
		mframe_out = enable_in ? (bit_cnt == 0 && frame_idx_out == 5'h00) : 1'($urandom);
		tx_serial_data_out = data_level_in;
	end
endmodule

// File: testbench/ttsos_top_tb.sv
// Bench for ttsos_top: registers, pin direction, F bits, system framing.
// Assumes the partner model drives the backplane side.
`timescale 1ns/1ps
module ttsos_top_tb;
	logic clock_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [11:0] reg_addr_in = 12'h000;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic [7:0] v;
	logic [4:0] m_idx;
	logic sclk, sdata, m_fb, m_mf, fb_out, fb_oe, mf_out, mf_oe, ld, ls;
	logic tick = 1'b0;
	logic sys_en = 1'b0;
	logic d_lvl = 1'b0;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	int tk = 0;
	int fr = -1;
	int mf_seen = 0;
	logic [5:0] crc_exp;
	always #12.5 clock_in = ~clock_in;
	// Ceiling covers a full multiframe wait plus twenty-six checked frames
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		tk <= (tk == 25) ? 0 : tk + 1;
		tick <= (tk == 25);
		if (cyc == 90000) begin
			failures = failures + 1;
			close_out();
		end
	end
	ttsos_top ttsos_top_inst (.clock_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
		.reg_write_in, .reg_read_in, .reg_rdata_out, .tx_serial_clock_in(sclk),
		.tx_serial_data_in(sdata), .recovered_clock_tick_in(tick),
		.tx_frame_boundary_in(fb_oe ? fb_out : m_fb), .tx_frame_boundary_out(fb_out),
		.tx_frame_boundary_oe_out(fb_oe), .tx_multiframe_boundary_in(mf_oe ? mf_out : m_mf),
		.tx_multiframe_boundary_out(mf_out), .tx_multiframe_boundary_oe_out(mf_oe),
		.tx_line_data_out(ld), .tx_line_strobe_out(ls));
	ttsos_sys_model ttsos_sys_model_inst (.enable_in(sys_en), .data_level_in(d_lvl),
		.tx_serial_clock_out(sclk), .tx_serial_data_out(sdata), .frame_out(m_fb),
		.mframe_out(m_mf), .frame_idx_out(m_idx));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge clock_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		@(negedge clock_in);
		v = reg_rdata_out;
	endtask
	// CRC-6 of one multiframe with every F bit one and every payload bit d
	function automatic logic [5:0] crc_of(input logic d);
		logic [5:0] c;
		logic fb;
		c = 6'h00;
		for (int i = 0; i < 24 * 193; i++) begin
			fb = ((i % 193 == 0) ? 1'b1 : d) ^ c[5];
			c = {c[4:0], 1'b0} ^ (fb ? ttsos_pkg::CRC6_POLY : 6'h00);
		end
		return c;
	endfunction
	// Follows the F bits marked by the chip's own boundary outputs
	task automatic fbits(input int nf, input logic fsrc, input logic csrc);
		int n;
		n = 0;
		while (n < nf) begin
			@(negedge clock_in);
			if (ls && fb_out) begin
				fr = mf_out ? 0 : (fr < 0) ? -1 : (fr + 1) % 24;
				if (mf_out)
					mf_seen++;
				if (fr >= 0) begin
					n++;
					if (fsrc)
						check({7'h00, ld}, {7'h00, d_lvl});
					else if (fr % 4 == 3)
						check({7'h00, ld}, {7'h00, ttsos_pkg::FPS_PATTERN[5 - fr / 4]});
					else if (fr % 4 == 1 && csrc)
						check({7'h00, ld}, {7'h00, d_lvl});
					else if (fr % 4 == 1 && mf_seen > 1)
						check({7'h00, ld}, {7'h00, crc_exp[5 - fr / 4]});
					else if (fr % 4 != 1)
						check({7'h00, ld}, 8'h01);
				end
			end
		end
	endtask
	task automatic close_out;
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		int r;
		logic e;
		logic sync;
		r = $urandom(93);
		sync = 1'b0;
		repeat (10) @(posedge clock_in);
		resetn_in <= 1'b1;
		rd(12'h109);
		check(v, 8'h00);
		rd(12'h1f0);
		check(v, 8'h01);
		rd(12'h0a5);
		check(v, 8'h00);
		r = $urandom;
		wr(12'h109, r[7:0]);
		rd(12'h109);
		check(v, r[7:0] & 8'h13);
		for (int s = 0; s < 8; s++) begin
			wr(12'h100, {6'h00, s[1:0]});
			wr(12'h109, {3'h0, s[2], 4'h0});
			rd(12'h1f1);
			e = (s[1:0] == 2'h1) ? s[2] : !s[2];
			check({7'h00, fb_oe}, {7'h00, e});
			check({7'h00, mf_oe}, {7'h00, e});
			check({7'h00, v[7]}, {7'h00, e});
		end
		sys_en <= 1'b1;
		d_lvl <= r[8];
		crc_exp = crc_of(r[8]);
		wr(12'h100, 8'h01);
		wr(12'h109, 8'h00);
		repeat (30) begin
			@(posedge m_fb);
			repeat (40) @(posedge clock_in);
			rd(12'h1f1);
			if (m_idx == 5'h00)
				sync = 1'b1;
			if (sync && m_idx == 5'h00)
				check(v & 8'h9f, 8'h00);
			else if (sync)
				check(v & 8'h9f, {3'h0, m_idx});
		end
		sys_en <= 1'b0;
		wr(12'h109, 8'h12);
		fbits(8, 1'b0, 1'b1);
		wr(12'h109, 8'h11);
		fbits(4, 1'b1, 1'b0);
		wr(12'h1f0, 8'h00);
		rd(12'h1f0);
		check(v, 8'h00);
		wr(12'h109, 8'h12);
		fbits(14, 1'b0, 1'b0);
		close_out();
	end
endmodule
